/* File: core/ebm_pkg.sv */
// Constants, register map and state type of the external bus cycle sequencer.
// Assumes one 50 MHz system clock and an 8-bit register port with printed offsets.
// Notes on behaviour
// - Latch style bus states last 2 to 15 clocks
// - Muxed T1: address on data, select, latch pulse
// - Muxed read T2: address off, read strobe, request
// - Ready low before T3 inserts waits; T3 idle
// - Latch read: capture at T4 start, drop strobe
// - Muxed write T2: data replaces address, write strobe
// - Latch write: strobe off at T4, hold buses
// - Strobe style runs S0-S7; S5 changes nothing, S3 only turns on write data drive
// - Strobe read: direction high S0, address S1, strobes S2
// - S4 waits for acknowledge in whole-state steps
// - Entering S7 read: capture data, drop strobes
// - Strobe write: direction high S0, low at S2
// - Strobe write drives data bus from S3
// - Strobe write: data strobe at S4, same wait
// - Write S7: strobes off, direction high after S7
// - Style switch costs one clock, except to native
// - Memory select compares address 23:16 with low bound
// - I/O select compares address 15:8 with low bound
// - High bound limits memory selects only
// - Low bound registers reset to zero
// - High bound zero resets ones, others zero
// - State length field 1..15, zero invalid
// - Share bit multiplexes low address onto data, latch style only
// - Memory select compares address 23:16 with high bound
// - Io flag marks select as I/O select
package ebm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int NUM_SEL = 4;
  localparam logic [7:0] OFS_LOW [NUM_SEL] = '{8'ha8, 8'hab, 8'hae, 8'hb1};
  localparam logic [7:0] OFS_HIGH [NUM_SEL] = '{8'ha9, 8'hac, 8'haf, 8'hb2};
  localparam logic [7:0] OFS_CFG [NUM_SEL] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3};
  localparam logic [7:0] OFS_EN = 8'hc4;
  localparam logic [7:0] OFS_STAT = 8'hc5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] HIGH0_RST = 8'hff;
  localparam logic [7:0] HIGH_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h02;
  localparam logic [3:0] EN_RST = 4'h0;

  // ****************************************
  // Configuration fields and codes
  // ****************************************
  localparam int CFG_STYLE_HI = 7;
  localparam int CFG_STYLE_LO = 6;
  localparam int CFG_SHARE = 5;
  localparam int CFG_IO = 4;
  localparam int CFG_LEN_HI = 3;
  localparam logic [1:0] STY_NATIVE = 2'h0;
  localparam logic [1:0] STY_LATCH = 2'h2;
  localparam logic [1:0] STY_STROBE = 2'h3;
  localparam logic [3:0] LEN_MIN = 4'h1;
  localparam logic [3:0] LEN_MIN_LATCH = 4'h2;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE, ST_NATIVE, ST_GAP,
    ST_T1, ST_T2, ST_TW, ST_T3, ST_T4,
    ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_SW, ST_S5, ST_S6, ST_S7
  } ebm_state_e;

endpackage : ebm_pkg

/* File: core/ebm_state_timer.sv */
// Counts the system clocks of one bus state.
// Assumes the sequencer holds run high while a timed state is in progress.
`timescale 1ns/10ps
module ebm_state_timer (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Control
  input wire logic run_i,
  input wire logic [3:0] len_i,
  // State position
  output logic last_o,
  output logic early_o
);

  logic [3:0] cnt_reg; // Clocks spent in the current state

  // Restart at every state boundary
  always_ff @(posedge mclk_i) begin
    if (srst_i || !run_i || last_o) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // Final clock of the state, and its first half
  assign last_o = run_i && (cnt_reg == len_i - 4'h1);
  assign early_o = cnt_reg < {1'b0, len_i[3:1]};

endmodule : ebm_state_timer

/* File: core/ebm_select_decode.sv */
// Decodes an access address into one of four chip selects.
// Assumes bound and flag values come straight from the register file.
`timescale 1ns/10ps
module ebm_select_decode (
  // Access
  input wire logic [23:0] addr_i,
  input wire logic io_access_i,
  // Select setup
  input wire logic [3:0] en_i,
  input wire logic [3:0] io_flag_i,
  input wire logic [3:0][7:0] low_i,
  input wire logic [3:0][7:0] high_i,
  // Result
  output logic [3:0] hit_o,
  output logic [1:0] idx_o,
  output logic any_o
);

  // Lowest numbered matching select wins
  always_comb begin
    logic m;
    m = 1'b0;
    hit_o = 4'h0;
    idx_o = 2'h0;
    any_o = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (io_flag_i[i]) begin
        m = io_access_i && (addr_i[15:8] == low_i[i]);
      end else begin
        m = !io_access_i && (addr_i[23:16] >= low_i[i])
          && (addr_i[23:16] <= high_i[i]);
      end
      if (en_i[i] && m) begin
        hit_o = 4'h0;
        hit_o[i] = 1'b1;
        idx_o = 2'(i);
        any_o = 1'b1;
      end
    end
  end

endmodule : ebm_select_decode

/* File: core/ebm_bus_sequencer.sv */
// External bus cycle sequencer with four chip selects.
// Assumes one 50 MHz clock, a core that raises one request at a time,
// and pins that reach the outside world through the pad ring.
`timescale 1ns/10ps
module ebm_bus_sequencer (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Access request from the core
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_io_i,
  input wire logic [23:0] req_addr_i,
  input wire logic [7:0] req_wdata_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  // External bus pins
  output logic [23:0] addr_o,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic [7:0] data_i,
  output logic [3:0] select_n_o,
  output logic address_latch_pulse_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic memory_request_n_o,
  output logic io_request_n_o,
  output logic address_strobe_n_o,
  output logic data_strobe_n_o,
  output logic read_not_write_o,
  input wire logic ready_i,
  input wire logic transfer_ack_n_i
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [3:0][7:0] low_reg; // Low bound per select
  logic [3:0][7:0] high_reg; // High bound per select
  logic [7:0] cfg_reg [ebm_pkg::NUM_SEL]; // Style, share, io flag, length
  logic [3:0] en_reg; // Select enables
  logic [3:0] io_flag; // Io flag per select
  logic [7:0] rd_next; // Register read mux
  logic [7:0] data_meta_reg, data_sync_reg; // Data bus synchroniser
  logic ready_meta_reg, ready_sync_reg; // Ready synchroniser
  logic ack_meta_reg, ack_sync_reg; // Acknowledge synchroniser
  ebm_pkg::ebm_state_e state_reg, state_next; // Sequencer state
  logic [3:0] hit; // Decoded selects
  logic [1:0] hit_idx; // Index of decoded select
  logic hit_any; // Any select decoded
  logic [1:0] new_style; // Style of the offered request
  logic [1:0] last_style_reg; // Style of the previous access
  logic [1:0] cur_style_reg; // Style of the running access
  logic [3:0] cur_sel_reg; // Selects of the running access
  logic [3:0] cur_len_reg; // Clocks per state
  logic cur_share_reg, cur_write_reg, cur_io_reg; // Access kind
  logic [23:0] cur_addr_reg; // Access address
  logic [7:0] cur_wdata_reg; // Write data
  logic accept; // Request taken this cycle
  logic timed; // State runs on the timer
  logic tim_last, tim_early; // Timer position
  logic capture; // Read data taken this cycle
  logic [23:0] addr_next;
  logic [7:0] data_next;
  logic oe_next, ale_next, rd_n_next, wr_n_next, memory_request_n_next, io_request_n_next;
  logic as_n_next, ds_n_next, rnw_next;
  logic [3:0] sel_n_next;

  // Clamp the state length to the legal range of the style
  function automatic logic [3:0] eff_len(input logic [1:0] sty, input logic [3:0] len);
    eff_len = len;
    if (len == 4'h0) begin
      eff_len = ebm_pkg::LEN_MIN;
    end
    if (sty == ebm_pkg::STY_LATCH && eff_len < ebm_pkg::LEN_MIN_LATCH) begin
      eff_len = ebm_pkg::LEN_MIN_LATCH;
    end
  endfunction : eff_len

  // ****************************************
  // Register file
  // ****************************************
  // Software writes, one register per offset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < ebm_pkg::NUM_SEL; i++) begin
        low_reg[i] <= ebm_pkg::LOW_RST;
        high_reg[i] <= (i == 0) ? ebm_pkg::HIGH0_RST : ebm_pkg::HIGH_RST;
        cfg_reg[i] <= ebm_pkg::CFG_RST;
      end
      en_reg <= ebm_pkg::EN_RST;
    end else if (reg_wr_i) begin
      for (int i = 0; i < ebm_pkg::NUM_SEL; i++) begin
        if (reg_addr_i == ebm_pkg::OFS_LOW[i]) low_reg[i] <= reg_wdata_i;
        if (reg_addr_i == ebm_pkg::OFS_HIGH[i]) high_reg[i] <= reg_wdata_i;
        if (reg_addr_i == ebm_pkg::OFS_CFG[i]) cfg_reg[i] <= reg_wdata_i;
      end
      if (reg_addr_i == ebm_pkg::OFS_EN) en_reg <= reg_wdata_i[3:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_next = 8'h00;
    for (int i = 0; i < ebm_pkg::NUM_SEL; i++) begin
      if (reg_addr_i == ebm_pkg::OFS_LOW[i]) rd_next = low_reg[i];
      if (reg_addr_i == ebm_pkg::OFS_HIGH[i]) rd_next = high_reg[i];
      if (reg_addr_i == ebm_pkg::OFS_CFG[i]) rd_next = cfg_reg[i];
    end
    if (reg_addr_i == ebm_pkg::OFS_EN) rd_next = {4'h0, en_reg};
    if (reg_addr_i == ebm_pkg::OFS_STAT) rd_next = {!req_ready_o, 1'b0, last_style_reg, cur_sel_reg};
  end

  // Read data stands for the one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_next : 8'h00;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      data_meta_reg <= 8'h00;
      data_sync_reg <= 8'h00;
      ready_meta_reg <= 1'b1;
      ready_sync_reg <= 1'b1;
      ack_meta_reg <= 1'b1;
      ack_sync_reg <= 1'b1;
    end else begin
      data_meta_reg <= data_i;
      data_sync_reg <= data_meta_reg;
      ready_meta_reg <= ready_i;
      ready_sync_reg <= ready_meta_reg;
      ack_meta_reg <= transfer_ack_n_i;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  // ****************************************
  // Select decode and request intake
  // ****************************************
  always_comb begin
    for (int i = 0; i < ebm_pkg::NUM_SEL; i++) io_flag[i] = cfg_reg[i][ebm_pkg::CFG_IO];
  end

  ebm_select_decode u_decode (
    .addr_i(req_addr_i),
    .io_access_i(req_io_i),
    .en_i(en_reg),
    .io_flag_i(io_flag),
    .low_i(low_reg),
    .high_i(high_reg),
    .hit_o(hit),
    .idx_o(hit_idx),
    .any_o(hit_any)
  );

  // Code 1 is not a supported style and runs as native
  always_comb begin
    new_style = hit_any ? cfg_reg[hit_idx][ebm_pkg::CFG_STYLE_HI:ebm_pkg::CFG_STYLE_LO] : ebm_pkg::STY_NATIVE;
    if (new_style != ebm_pkg::STY_LATCH && new_style != ebm_pkg::STY_STROBE) new_style = ebm_pkg::STY_NATIVE;
  end

  assign req_ready_o = (state_reg == ebm_pkg::ST_IDLE);
  assign accept = req_ready_o && req_i;

  // Latch the access when it is taken
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cur_style_reg <= ebm_pkg::STY_NATIVE;
      last_style_reg <= ebm_pkg::STY_NATIVE;
      cur_sel_reg <= 4'h0;
      cur_len_reg <= ebm_pkg::LEN_MIN;
      cur_share_reg <= 1'b0;
      cur_write_reg <= 1'b0;
      cur_io_reg <= 1'b0;
      cur_addr_reg <= 24'h000000;
      cur_wdata_reg <= 8'h00;
    end else if (accept) begin
      cur_style_reg <= new_style;
      last_style_reg <= new_style;
      cur_sel_reg <= hit;
      cur_len_reg <= eff_len(new_style, cfg_reg[hit_idx][ebm_pkg::CFG_LEN_HI:0]);
      cur_share_reg <= cfg_reg[hit_idx][ebm_pkg::CFG_SHARE];
      cur_write_reg <= req_write_i;
      cur_io_reg <= req_io_i;
      cur_addr_reg <= req_addr_i;
      cur_wdata_reg <= req_wdata_i;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign timed = !(state_reg inside {ebm_pkg::ST_IDLE, ebm_pkg::ST_NATIVE, ebm_pkg::ST_GAP});

  ebm_state_timer u_timer (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .run_i(timed),
    .len_i(cur_len_reg),
    .last_o(tim_last),
    .early_o(tim_early)
  );

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ebm_pkg::ST_IDLE: begin
        if (req_i) begin
          if (new_style == ebm_pkg::STY_NATIVE) state_next = ebm_pkg::ST_NATIVE;
          else if (new_style != last_style_reg) state_next = ebm_pkg::ST_GAP;
          else if (new_style == ebm_pkg::STY_LATCH) state_next = ebm_pkg::ST_T1;
          else state_next = ebm_pkg::ST_S0;
        end
      end
      ebm_pkg::ST_NATIVE: state_next = ebm_pkg::ST_IDLE;
      // One spare clock before a new non-native style
      ebm_pkg::ST_GAP: begin
        state_next = (cur_style_reg == ebm_pkg::STY_LATCH) ? ebm_pkg::ST_T1 : ebm_pkg::ST_S0;
      end
      ebm_pkg::ST_T1: if (tim_last) state_next = ebm_pkg::ST_T2;
      ebm_pkg::ST_T2: if (tim_last) state_next = ready_sync_reg ? ebm_pkg::ST_T3 : ebm_pkg::ST_TW;
      ebm_pkg::ST_TW: if (tim_last && ready_sync_reg) state_next = ebm_pkg::ST_T3;
      ebm_pkg::ST_T3: if (tim_last) state_next = ebm_pkg::ST_T4;
      ebm_pkg::ST_T4: if (tim_last) state_next = ebm_pkg::ST_IDLE;
      ebm_pkg::ST_S0: if (tim_last) state_next = ebm_pkg::ST_S1;
      ebm_pkg::ST_S1: if (tim_last) state_next = ebm_pkg::ST_S2;
      ebm_pkg::ST_S2: if (tim_last) state_next = ebm_pkg::ST_S3;
      ebm_pkg::ST_S3: if (tim_last) state_next = ebm_pkg::ST_S4;
      ebm_pkg::ST_S4: if (tim_last) state_next = ack_sync_reg ? ebm_pkg::ST_SW : ebm_pkg::ST_S5;
      ebm_pkg::ST_SW: if (tim_last && !ack_sync_reg) state_next = ebm_pkg::ST_S5;
      ebm_pkg::ST_S5: if (tim_last) state_next = ebm_pkg::ST_S6;
      ebm_pkg::ST_S6: if (tim_last) state_next = ebm_pkg::ST_S7;
      ebm_pkg::ST_S7: if (tim_last) state_next = ebm_pkg::ST_IDLE;
      default: state_next = ebm_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (srst_i) state_reg <= ebm_pkg::ST_IDLE;
    else state_reg <= state_next;
  end

  // Read data is taken when T4 or S7 is entered
  assign capture = !cur_write_reg && (state_next != state_reg)
    && (state_next inside {ebm_pkg::ST_T4, ebm_pkg::ST_S7});

  // Completion pulse and read data
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= (state_reg != ebm_pkg::ST_IDLE) && (state_next == ebm_pkg::ST_IDLE);
      if (capture) rdata_o <= data_sync_reg;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Pin levels follow the state one clock later
  always_comb begin
    sel_n_next = 4'hf;
    addr_next = addr_o;
    data_next = cur_wdata_reg;
    oe_next = 1'b0;
    ale_next = 1'b0;
    rd_n_next = 1'b1;
    wr_n_next = 1'b1;
    memory_request_n_next = 1'b1;
    io_request_n_next = 1'b1;
    as_n_next = 1'b1;
    ds_n_next = 1'b1;
    rnw_next = 1'b1;
    case (state_reg)
      // Address phase with latch pulse in the first half
      ebm_pkg::ST_T1: begin
        sel_n_next = ~cur_sel_reg;
        addr_next = cur_addr_reg;
        ale_next = tim_early;
        if (cur_share_reg) begin
          oe_next = 1'b1;
          data_next = cur_addr_reg[7:0];
        end else begin
          oe_next = cur_write_reg;
        end
      end
      // Strobe phase; waits and T3 leave every pin as is
      ebm_pkg::ST_T2, ebm_pkg::ST_TW, ebm_pkg::ST_T3: begin
        sel_n_next = ~cur_sel_reg;
        addr_next = cur_addr_reg;
        rd_n_next = cur_write_reg;
        wr_n_next = !cur_write_reg;
        memory_request_n_next = cur_io_reg;
        io_request_n_next = !cur_io_reg;
        oe_next = cur_write_reg;
      end
      // Strobes off, buses held to the end
      ebm_pkg::ST_T4: begin
        sel_n_next = ~cur_sel_reg;
        addr_next = cur_addr_reg;
        oe_next = cur_write_reg;
      end
      // Direction high before the address
      ebm_pkg::ST_S0: begin
        sel_n_next = ~cur_sel_reg;
        rnw_next = 1'b1;
      end
      ebm_pkg::ST_S1: begin
        sel_n_next = ~cur_sel_reg;
        addr_next = cur_addr_reg;
      end
      // Address strobe active from S2 through S6; data strobe from S2 on a read, from S4 on a write
      ebm_pkg::ST_S2, ebm_pkg::ST_S3, ebm_pkg::ST_S4, ebm_pkg::ST_SW, ebm_pkg::ST_S5, ebm_pkg::ST_S6: begin
        sel_n_next = ~cur_sel_reg;
        addr_next = cur_addr_reg;
        as_n_next = 1'b0;
        rnw_next = !cur_write_reg;
        ds_n_next = cur_write_reg && (state_reg inside {ebm_pkg::ST_S2, ebm_pkg::ST_S3});
        oe_next = cur_write_reg && (state_reg != ebm_pkg::ST_S2);
      end
      // Strobes off; a write keeps direction low until S7 ends
      ebm_pkg::ST_S7: begin
        sel_n_next = ~cur_sel_reg;
        addr_next = cur_addr_reg;
        rnw_next = !cur_write_reg;
        oe_next = cur_write_reg;
      end
      default: ;
    endcase
  end

  // Registered pins
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      addr_o <= 24'h000000;
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      select_n_o <= 4'hf;
      address_latch_pulse_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      memory_request_n_o <= 1'b1;
      io_request_n_o <= 1'b1;
      address_strobe_n_o <= 1'b1;
      data_strobe_n_o <= 1'b1;
      read_not_write_o <= 1'b1;
    end else begin
      addr_o <= addr_next;
      data_o <= data_next;
      data_oe_o <= oe_next;
      select_n_o <= sel_n_next;
      address_latch_pulse_o <= ale_next;
      read_strobe_n_o <= rd_n_next;
      write_strobe_n_o <= wr_n_next;
      memory_request_n_o <= memory_request_n_next;
      io_request_n_o <= io_request_n_next;
      address_strobe_n_o <= as_n_next;
      data_strobe_n_o <= ds_n_next;
      read_not_write_o <= rnw_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  logic [3:0] dwell_reg; // Clocks spent in the current state
  always_ff @(posedge mclk_i) begin
    // A wait state that repeats itself starts a fresh bus state as well
    if (srst_i || state_next != state_reg
        || (tim_last && state_reg inside {ebm_pkg::ST_TW, ebm_pkg::ST_SW})) dwell_reg <= 4'h0;
    else dwell_reg <= dwell_reg + 4'h1;
  end

  state_dwell_a: assert property (timed && state_next != state_reg |->
    5'(dwell_reg) + 5'h1 == {1'b0, cur_len_reg}) else $error("bus state length wrong");
  latch_pulse_a: assert property (address_latch_pulse_o |->
    $past(state_reg) == ebm_pkg::ST_T1 && select_n_o != 4'hf) else $error("latch pulse outside T1");
  read_strobe_a: assert property (!read_strobe_n_o |-> !data_oe_o &&
    (memory_request_n_o != io_request_n_o)) else $error("read strobe with bus driven");
  ready_wait_a: assert property (state_reg == ebm_pkg::ST_T2 && tim_last && !ready_sync_reg
    |=> state_reg == ebm_pkg::ST_TW) else $error("ready low did not insert wait");
  read_capture_a: assert property (capture |=> rdata_o == $past(data_sync_reg))
    else $error("read data not captured");
  write_data_a: assert property (!write_strobe_n_o |-> data_oe_o
    && data_o == cur_wdata_reg) else $error("write strobe without write data");
  ack_wait_a: assert property (state_reg == ebm_pkg::ST_S4 && tim_last && ack_sync_reg
    |=> state_reg == ebm_pkg::ST_SW) else $error("missing acknowledge did not wait");
  s7_strobes_a: assert property ($past(state_reg) == ebm_pkg::ST_S7 |->
    address_strobe_n_o && data_strobe_n_o) else $error("strobes active in S7");
  style_gap_a: assert property (accept && new_style != ebm_pkg::STY_NATIVE
    && new_style != last_style_reg |=> state_reg == ebm_pkg::ST_GAP ##1 state_reg != ebm_pkg::ST_GAP)
    else $error("style switch penalty wrong");
  bound_reset_a: assert property ($fell(srst_i) |-> low_reg == 32'h0 && high_reg[0] == 8'hff)
    else $error("bound reset value wrong");

  latch_read_c: cover property (state_reg == ebm_pkg::ST_T4 && !cur_write_reg);
  strobe_write_wait_c: cover property (state_reg == ebm_pkg::ST_SW && cur_write_reg);
  style_gap_c: cover property (state_reg == ebm_pkg::ST_GAP);

endmodule : ebm_bus_sequencer

/* File: verif/ebm_periph_model.sv */
// Peripheral model: read data, ready and acknowledge.
// Assumes pins come straight from the sequencer.
`timescale 1ns/10ps
module ebm_periph_model (
  // Clock and mode
  input wire logic mclk_i,
  input wire logic slow_i,
  // Device pins
  input wire logic [3:0] sel_n_i,
  input wire logic rd_n_i,
  input wire logic ds_n_i,
  input wire logic rnw_i,
  // Answers
  output logic ready_o,
  output logic ack_n_o,
  output logic [7:0] data_o
);
  logic idle; // No select low
  logic [3:0] cnt_reg = 4'h0; // Clocks into access
  logic seen_reg = 1'b0; // Data strobe seen
  logic [7:0] pat_reg = 8'h96; // Filler off the bus
  assign idle = &sel_n_i;
  // Restart per access; filler toggles
  always @(posedge mclk_i) begin
    pat_reg <= ~pat_reg;
    cnt_reg <= idle ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hf};
    seen_reg <= !idle && (seen_reg || !ds_n_i);
  end
  // Slow peer holds ready low, acks late
  assign ready_o = idle || !slow_i || cnt_reg > 4'h7;
  assign ack_n_o = idle || (seen_reg && ds_n_i) || (slow_i && cnt_reg < 4'h8);
  // Drive 5a only under a read strobe or a data strobe with direction high, filler otherwise
  assign data_o = (!rd_n_i || (!ds_n_i && rnw_i)) ? 8'h5a : pat_reg;
endmodule : ebm_periph_model

/* File: verif/ebm_bus_sequencer_test.sv */
// Self-checking bench for the bus sequencer.
// Assumes the peripheral model is compiled first.
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, s); end end
module ebm_bus_sequencer_test;
  // Stimulus and pins
  logic mclk = 1'b0, srst = 1'b1, wr = 1'b0, rr = 1'b0, req = 1'b0, rw = 1'b0, io = 1'b0, slow = 1'b0;
  logic [7:0] ra = 8'h00, wd = 8'h00, rdat, rv, pd, din;
  logic [23:0] qa = 24'h000000, pa;
  logic rdy, ack_n, done, rs_n, ws_n, ds_n, rnw, oe, qr;
  logic [3:0] sel_n;
  int errors = 0, num_checks = 0, n;
  always #10 mclk = ~mclk;
  ebm_bus_sequencer uut (.mclk_i(mclk), .srst_i(srst), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rr), .reg_rdata_o(rdat), .req_i(req), .req_write_i(rw), .req_io_i(io), .req_addr_i(qa),
    .req_wdata_i(8'hc3), .req_ready_o(qr), .done_o(done), .rdata_o(rv), .addr_o(pa), .data_o(pd),
    .data_oe_o(oe), .data_i(din), .select_n_o(sel_n), .address_latch_pulse_o(), .read_strobe_n_o(rs_n),
    .write_strobe_n_o(ws_n), .memory_request_n_o(), .io_request_n_o(), .address_strobe_n_o(),
    .data_strobe_n_o(ds_n), .read_not_write_o(rnw), .ready_i(rdy), .transfer_ack_n_i(ack_n));
  ebm_periph_model peer (.mclk_i(mclk), .slow_i(slow), .sel_n_i(sel_n), .rd_n_i(rs_n), .ds_n_i(ds_n),
    .rnw_i(rnw), .ready_o(rdy), .ack_n_o(ack_n), .data_o(din));
  // Register write cycle
  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge mclk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_wr
  // Register read, data checked next cycle
  task automatic reg_chk(input logic [7:0] a, e);
    @(posedge mclk);
    ra <= a;
    rr <= 1'b1;
    @(posedge mclk);
    rr <= 1'b0;
    @(posedge mclk);
    `CHK("reg", e, rdat)
  endtask : reg_chk
  // One access; cycles from take to done in lo..hi
  task automatic acc(input logic w, i, input logic [23:0] a, input int lo, hi);
    @(posedge mclk);
    req <= 1'b1;
    rw <= w;
    io <= i;
    qa <= a;
    @(posedge mclk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (!ws_n || (!ds_n && !rnw)) `CHK("wdata", 9'h1c3, {oe, pd})
      if (!(rs_n && ws_n && ds_n)) `CHK("addr", a, pa)
      `CHK("ready", done, qr)
    end while (!done && n < 300);
    `CHK("cycles", 1'b1, n >= lo && n <= hi)
  endtask : acc
  // Verdict and end of run
  task automatic test_done;
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // Watchdog against a hang
  initial begin
    #200000;
    errors++;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      reg_chk(ebm_pkg::OFS_LOW[s], 8'h00);
      reg_chk(ebm_pkg::OFS_HIGH[s], s == 0 ? 8'hff : 8'h00);
    end
    reg_chk(8'h10, 8'h00);
    // Select 0 latch style, shared then separate bus, 2 clocks a state
    reg_wr(8'hc0, 8'ha2);
    reg_wr(8'hc4, 8'h01);
    acc(1'b0, 1'b0, 24'h123456, 10, 10);
    `CHK("rdata", 8'h5a, rv)
    acc(1'b1, 1'b0, 24'h123456, 9, 9);
    reg_wr(8'hc0, 8'h80);
    acc(1'b0, 1'b0, 24'h123456, 9, 9);
    acc(1'b1, 1'b0, 24'h123456, 9, 9);
    slow <= 1'b1;
    acc(1'b0, 1'b0, 24'h123456, 11, 40);
    slow <= 1'b0;
    // Select 1 strobe style, I/O, 1 clock a state
    reg_wr(8'hab, 8'h34);
    reg_wr(8'hc1, 8'hd1);
    reg_wr(8'hc4, 8'h02);
    acc(1'b0, 1'b1, 24'h00340f, 10, 10);
    `CHK("rdata", 8'h5a, rv)
    acc(1'b1, 1'b1, 24'h00340f, 9, 9);
    acc(1'b0, 1'b1, 24'h00350f, 2, 2);
    slow <= 1'b1;
    acc(1'b0, 1'b1, 24'h00340f, 10, 60);
    slow <= 1'b0;
    // Memory bounds on select 0
    reg_wr(8'hc4, 8'h01);
    reg_wr(8'ha8, 8'h10);
    reg_wr(8'ha9, 8'h20);
    reg_chk(8'ha8, 8'h10);
    acc(1'b0, 1'b0, 24'h200000, 10, 10);
    acc(1'b0, 1'b0, 24'h210000, 2, 2);
    acc(1'b0, 1'b0, 24'h0f0000, 2, 2);
    test_done;
  end
endmodule : ebm_bus_sequencer_test
